// *** rx_buf_if.sv ***
`timescale 1ns/1ns
interface rx_buf_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport src  (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport buff (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
endinterface : rx_buf_if

// *** rx_skid_buf.sv ***
`timescale 1ns/1ns
module rx_skid_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // buffer ports
  rx_buf_if.buff    bus
);
  if (DEPTH != 2) begin : g_bad_depth
    $error("rx_skid_buf supports depth 2 only");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [1:0]   cnt_q, cnt_d;
  logic         wr, rd;

  assign bus.in_ready  = (cnt_q != 2'd2);
  assign bus.out_valid = (cnt_q != 2'd0);
  assign bus.out_data  = mem_q[0];

  always_comb begin
    wr       = bus.in_valid && bus.in_ready;
    rd       = bus.out_valid && bus.out_ready;
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    cnt_d    = cnt_q;
    if (rd) begin
      mem_d[0] = mem_q[1];
    end
    if (wr) begin
      if (cnt_q == 2'd0 || (cnt_q == 2'd1 && rd)) mem_d[0] = bus.in_data;
      else mem_d[1] = bus.in_data;
    end
    cnt_d = cnt_q + {1'b0, wr} - {1'b0, rd};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q    <= 2'd0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      cnt_q    <= cnt_d;
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
    end
  end

  property p_no_overfill;
    @(posedge i_clk) disable iff (!i_rst_n)
      cnt_q != 2'd3;
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("buffer count out of range");
endmodule : rx_skid_buf

// *** spi_far_end.sv ***
`timescale 1ns/1ns
module spi_far_end (
  // pins seen from the block
  input  wire logic i_dut_sck,
  input  wire logic i_dut_mosi,
  // pins driven by this end
  output logic      o_sck,
  output logic      o_ss_n,
  output logic      o_mosi,
  output logic      o_miso
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  int         bit_idx;

  initial begin
    o_sck   = 1'b0;
    o_ss_n  = 1'b1;
    o_mosi  = 1'b0;
    o_miso  = 1'b0;
    tx_byte = 8'h00;
    rx_byte = 8'h00;
    bit_idx = 0;
  end

  task automatic select(input logic v);
    o_ss_n = ~v;
  endtask : select

  // master role, clock_phase 1: shift on the leading edge, sample on the trailing
  task automatic send_byte(input logic [7:0] b, input logic sel);
    o_ss_n = ~sel;
    #400;
    for (int i = 7; i >= 0; i--) begin
      o_sck  = 1'b1;
      o_mosi = b[i];
      #200;
      o_sck = 1'b0;
      #200;
    end
    #200;
    o_ss_n = 1'b1;
    // released data line must not keep the last bit
    o_mosi = ~o_mosi;
  endtask : send_byte

  task automatic prime(input logic [7:0] b);
    tx_byte = b;
    bit_idx = 0;
    o_miso  = b[7];
  endtask : prime

  // slave role on the block's own clock: the block moves its data line
  // just after the rise, so sample on the rise and present on the fall
  always @(posedge i_dut_sck) begin
    rx_byte <= {rx_byte[6:0], i_dut_mosi};
    bit_idx <= bit_idx + 1;
  end
  always @(negedge i_dut_sck) begin
    if (bit_idx < 8) begin
      o_miso <= tx_byte[7 - bit_idx];
    end else begin
      // released data line must not keep the last bit
      o_miso <= ~o_miso;
    end
  end
endmodule : spi_far_end

// *** spi_req_ctrl.sv ***
`timescale 1ns/1ns
// What this block does
// - tx request needs enable and unit enable
// - rx request ignores unit enable
// - error irq from overrun or select fault
// - select fault never set when disabled
// - cpu mode: status read then data read
// - dma mode: any data read clears rx
// - data write clears tx empty flag
// - system reset restores everything
// - disabled: tx empty, abort, release pins
// - control bits and rx full, overrun, fault flags survive disable
// - master select fault clears unit enable
// - stop halts; reset aborts and resets
// - break clearing allowed keeps flags cleared
// - break protect keeps flags and steps
// - protected break data write does nothing
// - miso driven only as selected slave
// - enabled unit owns pin directions
// - master drives clock; eight cycles each
// - deselected slave ignores clock edges
// - select input only slave or fault-enabled
// - fault clear: status read, control write
// - overrun clear; no move while set
module spi_req_ctrl #(
  parameter int HALF_CYC = spi_req_pkg::SCK_HALF_CYC
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // control bits
  input  wire logic       i_unit_enable_wr,
  input  wire logic       i_unit_enable_val,
  input  wire logic       i_master_select,
  input  wire logic       i_clock_phase,
  input  wire logic       i_clock_polarity,
  input  wire logic       i_dma_select,
  input  wire logic       i_tx_req_enable,
  input  wire logic       i_rx_req_enable,
  input  wire logic       i_error_irq_enable,
  input  wire logic       i_select_fault_enable,
  // mode inputs
  input  wire logic       i_stop_mode,
  input  wire logic       i_break_active,
  input  wire logic       i_break_clear_enable,
  // access strobes
  input  wire logic       i_status_rd,
  input  wire logic       i_data_rd,
  input  wire logic       i_data_wr,
  input  wire logic       i_control_wr,
  input  wire logic [7:0] i_data_wdata,
  // pins
  input  wire logic       i_sck,
  input  wire logic       i_ss_n,
  input  wire logic       i_miso,
  input  wire logic       i_mosi,
  output logic            o_sck,
  output logic            o_sck_oe,
  output logic            o_mosi,
  output logic            o_mosi_oe,
  output logic            o_miso,
  output logic            o_miso_oe,
  // status and requests
  output logic            o_unit_enable,
  output logic            o_tx_empty_flag,
  output logic            o_rx_full_flag,
  output logic            o_overrun_flag,
  output logic            o_select_fault_flag,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_irq,
  output logic            o_tx_dma,
  output logic            o_rx_irq,
  output logic            o_rx_dma,
  output logic            o_err_irq
);
  if (HALF_CYC < 1 || HALF_CYC > 256) begin : g_bad_half
    $error("HALF_CYC must lie between 1 and 256");
  end

  // three-stage samplers on pins
  logic [2:0] sck_s_q, ss_s_q, miso_s_q, mosi_s_q;
  logic       sck_f_q, ss_f_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_s_q  <= '0;
      ss_s_q   <= 3'b111;
      miso_s_q <= '0;
      mosi_s_q <= '0;
      sck_f_q  <= 1'b0;
      ss_f_q   <= 1'b1;
    end else begin
      sck_s_q  <= {sck_s_q[1:0], i_sck};
      ss_s_q   <= {ss_s_q[1:0], i_ss_n};
      miso_s_q <= {miso_s_q[1:0], i_miso};
      mosi_s_q <= {mosi_s_q[1:0], i_mosi};
      if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
      if (ss_s_q[1] == ss_s_q[2]) ss_f_q <= ss_s_q[2];
    end
  end
  logic sck_now, ss_n;
  assign sck_now = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
  assign ss_n    = (ss_s_q[1] == ss_s_q[2]) ? ss_s_q[2] : ss_f_q;

  // state
  spi_req_pkg::xfer_state_t st_q, st_d;
  logic       en_q, en_d;
  logic       tx_e_q, tx_e_d, rx_f_q, rx_f_d, ovr_q, ovr_d, sf_q, sf_d;
  logic       rx_arm_q, rx_arm_d, ovr_arm_q, ovr_arm_d, sf_arm_q, sf_arm_d;
  logic [7:0] txb_q, txb_d, sh_q, sh_d, rxd_q, rxd_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] div_q, div_d;
  logic       sck_q, sck_d, lead_q, lead_d;
  logic       tx_pend_q, tx_pend_d;
  logic       ss_prev_q, sck_prev_q;

  // received bytes pass a two-entry buffer toward the receive register
  rx_buf_if #(.W(spi_req_pkg::BYTE_BITS)) rb ();
  rx_skid_buf #(.W(spi_req_pkg::BYTE_BITS), .DEPTH(spi_req_pkg::BUF_DEPTH))
    u_buf (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(rb));

  logic run, ss_used, ss_sel, protect, sck_rise, sck_fall, ss_fall, ss_rise;
  logic sample_edge, byte_done, fault, rx_move;
  always_comb begin
    run      = en_q && !i_stop_mode;
    ss_used  = en_q && (!i_master_select || i_select_fault_enable);
    ss_sel   = ss_used && !ss_n;
    protect  = i_break_active && !i_break_clear_enable;
    sck_rise = sck_now && !sck_prev_q;
    sck_fall = !sck_now && sck_prev_q;
    ss_fall  = !ss_n && ss_prev_q;
    ss_rise  = ss_n && !ss_prev_q;
    // slave: rise or fall by polarity xor phase; master: leading edge
    if (i_master_select) begin
      sample_edge = lead_q;
    end else begin
      sample_edge = ss_sel && ((i_clock_polarity ^ i_clock_phase) ?
                               sck_fall : sck_rise);
    end
    fault = i_select_fault_enable && en_q &&
            ((i_master_select && !ss_n) ||
             (!i_master_select && ss_rise && (st_q != spi_req_pkg::ST_IDLE ||
              !i_clock_phase)));
    byte_done = run && sample_edge && (bits_q == spi_req_pkg::BITS_PER_BYTE
                                       - 4'h1);
    rx_move   = rb.out_valid && !ovr_q && !rx_f_q;
  end

  assign rb.in_valid  = byte_done;
  assign rb.in_data   = {sh_q[6:0], i_master_select ? miso_s_q[2]
                                                    : mosi_s_q[2]};
  assign rb.out_ready = rx_move || (rb.out_valid && rx_f_q && !ovr_q &&
                                    byte_done);

  always_comb begin
    st_d = st_q; en_d = en_q; tx_e_d = tx_e_q; rx_f_d = rx_f_q;
    ovr_d = ovr_q; sf_d = sf_q; rx_arm_d = rx_arm_q; ovr_arm_d = ovr_arm_q;
    sf_arm_d = sf_arm_q; txb_d = txb_q; sh_d = sh_q; rxd_d = rxd_q;
    bits_d = bits_q; div_d = div_q; sck_d = sck_q; lead_d = 1'b0;
    tx_pend_d = tx_pend_q;
    if (i_unit_enable_wr) en_d = i_unit_enable_val;
    // software clearing steps, frozen during protected break
    if (!protect) begin
      if (i_status_rd) begin
        rx_arm_d  = rx_f_q;
        ovr_arm_d = ovr_q;
        sf_arm_d  = sf_q;
      end
      if (i_data_rd) begin
        if (i_dma_select || rx_arm_q) rx_f_d = 1'b0;
        if (ovr_arm_q) ovr_d = 1'b0;
        rx_arm_d = 1'b0;
        ovr_arm_d = 1'b0;
      end
      if (i_control_wr) begin
        if (sf_arm_q) sf_d = 1'b0;
        sf_arm_d = 1'b0;
      end
      if (i_data_wr) begin
        tx_e_d    = 1'b0;
        txb_d     = i_data_wdata;
        tx_pend_d = 1'b1;
      end
    end
    if (fault) begin
      sf_d = 1'b1;
      sf_arm_d = 1'b0;
      if (i_master_select) en_d = 1'b0;
    end
    if (rx_move) begin
      rxd_d  = rb.out_data;
      rx_f_d = 1'b1;
    end
    if (byte_done && (rx_f_q || ovr_q) && !rx_move) ovr_d = 1'b1;
    // transfer engine
    if (run) begin
      case (st_q)
        spi_req_pkg::ST_IDLE: begin
          if (tx_pend_q && (i_master_select || ss_sel)) begin
            sh_d = txb_q; tx_pend_d = 1'b0; tx_e_d = 1'b1;
            bits_d = '0; div_d = '0;
            st_d = spi_req_pkg::ST_SHIFT;
          end else if (!i_master_select && ss_sel && ss_fall) begin
            sh_d = spi_req_pkg::RST_BYTE; bits_d = '0;
            st_d = spi_req_pkg::ST_SHIFT;
          end
        end
        spi_req_pkg::ST_SHIFT: begin
          if (i_master_select) begin
            if (div_q == 8'(HALF_CYC - 1)) begin
              div_d = '0;
              sck_d = !sck_q;
              lead_d = (sck_q == i_clock_polarity);
            end else div_d = div_q + 8'h01;
          end
          if (sample_edge) begin
            sh_d = {sh_q[6:0], i_master_select ? miso_s_q[2]
                                               : mosi_s_q[2]};
            bits_d = bits_q + 4'h1;
            if (byte_done) st_d = spi_req_pkg::ST_DONE;
          end
          if (!i_master_select && ss_n) st_d = spi_req_pkg::ST_IDLE;
        end
        spi_req_pkg::ST_DONE: begin
          if (div_q == 8'(HALF_CYC - 1) || !i_master_select) begin
            sck_d = i_clock_polarity; div_d = '0;
            st_d = spi_req_pkg::ST_IDLE;
          end else div_d = div_q + 8'h01;
        end
        default: st_d = spi_req_pkg::ST_IDLE;
      endcase
    end
    if (!en_q) begin
      tx_e_d = 1'b1; st_d = spi_req_pkg::ST_IDLE;
      sh_d = spi_req_pkg::RST_BYTE; bits_d = '0; div_d = '0;
      sck_d = i_clock_polarity; tx_pend_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= spi_req_pkg::ST_IDLE; en_q <= 1'b0;
      tx_e_q <= spi_req_pkg::RST_TX_EMPTY; rx_f_q <= 1'b0;
      ovr_q <= 1'b0; sf_q <= 1'b0; rx_arm_q <= 1'b0;
      ovr_arm_q <= 1'b0; sf_arm_q <= 1'b0;
      txb_q <= spi_req_pkg::RST_BYTE; sh_q <= spi_req_pkg::RST_BYTE;
      rxd_q <= spi_req_pkg::RST_BYTE; bits_q <= '0; div_q <= '0;
      sck_q <= 1'b0; lead_q <= 1'b0; tx_pend_q <= 1'b0;
      ss_prev_q <= 1'b1; sck_prev_q <= 1'b0;
    end else begin
      st_q <= st_d; en_q <= en_d; tx_e_q <= tx_e_d; rx_f_q <= rx_f_d;
      ovr_q <= ovr_d; sf_q <= sf_d; rx_arm_q <= rx_arm_d;
      ovr_arm_q <= ovr_arm_d; sf_arm_q <= sf_arm_d;
      txb_q <= txb_d; sh_q <= sh_d; rxd_q <= rxd_d; bits_q <= bits_d;
      div_q <= div_d; sck_q <= sck_d; lead_q <= lead_d;
      tx_pend_q <= tx_pend_d; ss_prev_q <= ss_n; sck_prev_q <= sck_now;
    end
  end

  // registered outputs, requests are levels of flag and enables
  logic tx_req, rx_req, err_req;
  always_comb begin
    tx_req  = tx_e_d && i_tx_req_enable && en_d;
    rx_req  = rx_f_d && i_rx_req_enable;
    err_req = i_error_irq_enable && (ovr_d || sf_d);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_irq <= 1'b0; o_tx_dma <= 1'b0; o_rx_irq <= 1'b0;
      o_rx_dma <= 1'b0; o_err_irq <= 1'b0;
      o_unit_enable <= 1'b0; o_tx_empty_flag <= spi_req_pkg::RST_TX_EMPTY;
      o_rx_full_flag <= 1'b0; o_overrun_flag <= 1'b0;
      o_select_fault_flag <= 1'b0; o_rx_data <= spi_req_pkg::RST_BYTE;
      o_sck <= 1'b0; o_sck_oe <= 1'b0; o_mosi <= 1'b0; o_mosi_oe <= 1'b0;
      o_miso <= 1'b0; o_miso_oe <= 1'b0;
    end else begin
      o_tx_irq <= tx_req && !i_dma_select;
      o_tx_dma <= tx_req && i_dma_select;
      o_rx_irq <= rx_req && !i_dma_select;
      o_rx_dma <= rx_req && i_dma_select;
      o_err_irq <= err_req;
      o_unit_enable <= en_d; o_tx_empty_flag <= tx_e_d;
      o_rx_full_flag <= rx_f_d; o_overrun_flag <= ovr_d;
      o_select_fault_flag <= sf_d; o_rx_data <= rxd_d;
      o_sck <= sck_d;
      o_sck_oe <= en_d && i_master_select;
      o_mosi <= sh_d[7];
      o_mosi_oe <= en_d && i_master_select;
      o_miso <= sh_d[7];
      o_miso_oe <= en_d && !i_master_select && !ss_n;
    end
  end

  // checks
  property p_tx_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_tx_irq |-> (o_unit_enable && o_tx_empty_flag && !o_tx_dma);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx req gating");
  property p_rx_req;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_rx_irq || o_rx_dma) |-> o_rx_full_flag;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx req flag");
  property p_err;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_err_irq |-> (o_overrun_flag || o_select_fault_flag);
  endproperty
  a_err: assert property (p_err) else $error("err req source");
  property p_sf_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!i_select_fault_enable && !o_select_fault_flag) |=>
        !o_select_fault_flag || $past(i_select_fault_enable);
  endproperty
  a_sf_off: assert property (p_sf_off) else $error("fault set off");
  property p_dma_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_dma_select && i_data_rd && !protect && !rx_move) |=>
        !o_rx_full_flag;
  endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("dma rx clr");
  property p_tx_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_data_wr && !protect && en_q && !tx_pend_q) |=> !o_tx_empty_flag;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx clr");
  property p_dis;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!en_q && !(i_unit_enable_wr && i_unit_enable_val)) |=>
        (o_tx_empty_flag && !o_sck_oe && !o_mosi_oe);
  endproperty
  a_dis: assert property (p_dis) else $error("disable state");
  property p_miso;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_miso_oe |-> ($past(ss_n) == 1'b0);
  endproperty
  a_miso: assert property (p_miso) else $error("miso drive");
  property p_brk;
    @(posedge i_clk) disable iff (!i_rst_n)
      (protect && !byte_done && !rx_move && !fault && en_q) |=>
        $stable(o_rx_full_flag) && $stable(o_overrun_flag);
  endproperty
  a_brk: assert property (p_brk) else $error("break protect");
  c_byte: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    byte_done);
  c_ovr: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_overrun_flag));
  c_fault: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_select_fault_flag));
endmodule : spi_req_ctrl

// *** spi_req_pkg.sv ***
package spi_req_pkg;
  // frame and counts
  localparam int          BYTE_BITS     = 8;
  localparam int          BIT_CNT_W     = 4;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  // link clock divider for master mode: half period in system clocks
  localparam int          CLK_HZ        = 20000000;
  localparam int          SCK_HALF_NS   = 200;
  localparam int          SCK_HALF_CYC  = (SCK_HALF_NS * (CLK_HZ / 1000000)
                                           + 999) / 1000;
  // reset values of control bits, tx empty flag and data bytes
  localparam logic        RST_MASTER    = 1'b1;
  localparam logic        RST_CLOCK_PHASE      = 1'b1;
  localparam logic        RST_TX_EMPTY  = 1'b1;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  // buffer depth
  localparam int          BUF_DEPTH     = 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } xfer_state_t;
endpackage : spi_req_pkg

// *** spi_request_reset_pin_control_test.sv ***
`timescale 1ns/1ns
module spi_request_reset_pin_control_test;
  logic       i_clk, i_rst_n, unit_wr, unit_val, mst, dma, tx_en, rx_en;
  logic       err_en, sf_en, brk, bce, st_rd, d_rd, d_wr, c_wr;
  logic       clock_phase, cpol, stop;
  logic [7:0] wdata;
  logic       o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
  logic       o_en, o_txe, o_rxf, o_ovr, o_sf, tx_irq, tx_dma;
  logic       rx_irq, rx_dma, err_irq, f_sck, f_ss_n, f_mosi, f_miso;
  logic [7:0] o_rx_data;
  wire        sck_w  = o_sck_oe ? o_sck : f_sck;
  wire        mosi_w = o_mosi_oe ? o_mosi : f_mosi;
  wire        miso_w = o_miso_oe ? o_miso : f_miso;
  int         error_cnt, n_compared, sck_edges;

  spi_req_ctrl #(.HALF_CYC(4)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_unit_enable_wr(unit_wr),
    .i_unit_enable_val(unit_val), .i_master_select(mst),
    .i_clock_phase(clock_phase), .i_clock_polarity(cpol), .i_dma_select(dma),
    .i_tx_req_enable(tx_en), .i_rx_req_enable(rx_en),
    .i_error_irq_enable(err_en), .i_select_fault_enable(sf_en),
    .i_stop_mode(stop), .i_break_active(brk), .i_break_clear_enable(bce),
    .i_status_rd(st_rd), .i_data_rd(d_rd), .i_data_wr(d_wr),
    .i_control_wr(c_wr), .i_data_wdata(wdata), .i_sck(sck_w),
    .i_ss_n(f_ss_n), .i_miso(miso_w), .i_mosi(mosi_w), .o_sck(o_sck),
    .o_sck_oe(o_sck_oe), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_unit_enable(o_en),
    .o_tx_empty_flag(o_txe), .o_rx_full_flag(o_rxf),
    .o_overrun_flag(o_ovr), .o_select_fault_flag(o_sf),
    .o_rx_data(o_rx_data), .o_tx_irq(tx_irq), .o_tx_dma(tx_dma),
    .o_rx_irq(rx_irq), .o_rx_dma(rx_dma), .o_err_irq(err_irq));

  spi_far_end far (
    .i_dut_sck(o_sck & o_sck_oe), .i_dut_mosi(mosi_w), .o_sck(f_sck),
    .o_ss_n(f_ss_n), .o_mosi(f_mosi), .o_miso(f_miso));

  always @(posedge o_sck) begin
    if (o_sck_oe === 1'b1) begin
      sck_edges++;
    end
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  // one-cycle access strobe: 0 status rd, 1 data rd, 2 data wr, 3 ctrl wr
  task automatic strobe(input int which);
    @(negedge i_clk);
    case (which)
      0: st_rd = 1'b1;
      1: d_rd = 1'b1;
      2: d_wr = 1'b1;
      3: c_wr = 1'b1;
      default: unit_wr = 1'b1;
    endcase
    @(negedge i_clk);
    {st_rd, d_rd, d_wr, c_wr, unit_wr} = 5'h00;
    cyc(3);
  endtask : strobe

  task automatic en(input logic v);
    unit_val = v;
    strobe(4);
  endtask : en

  task automatic wait_rx();
    int k;
    cyc(1);
    for (k = 0; k < 500 && o_rxf !== 1'b1; k++) begin
      cyc(1);
    end
    check(o_rxf, 1'b1);
  endtask : wait_rx

  task automatic t_reset();
    check({o_txe, o_rxf, o_ovr, o_sf, o_en}, 8'h10);
    check({o_sck_oe, o_mosi_oe, o_miso_oe, tx_irq, err_irq}, 8'h00);
  endtask : t_reset

  task automatic t_tx_req();
    tx_en = 1'b1;
    cyc(3);
    check(tx_irq, 1'b0);
    en(1'b1);
    check({o_en, tx_irq, tx_dma}, 8'h06);
    check({o_sck_oe, o_mosi_oe}, 8'h03);
    dma = 1'b1;
    cyc(3);
    check({tx_irq, tx_dma}, 8'h01);
    dma = 1'b0;
    tx_en = 1'b0;
    cyc(3);
    check({tx_irq, tx_dma}, 8'h00);
    en(1'b0);
    check({o_sck_oe, o_mosi_oe, o_txe}, 8'h01);
  endtask : t_tx_req

  task automatic t_master_xfer();
    en(1'b1);
    far.prime(8'hc5);
    sck_edges = 0;
    wdata = 8'h3c;
    strobe(2);
    wait_rx();
    cyc(20);
    check(far.rx_byte, 8'h3c);
    check(o_rx_data, 8'hc5);
    check(sck_edges[7:0], 8'h08);
    strobe(0);
    strobe(1);
    check(o_rxf, 1'b0);
    brk = 1'b1;
    wdata = 8'h55;
    strobe(2);
    cyc(100);
    check(sck_edges[7:0], 8'h08);
    check(o_txe, 1'b1);
    brk = 1'b0;
    en(1'b0);
  endtask : t_master_xfer

  task automatic t_stop();
    en(1'b1);
    far.prime(8'h9a);
    sck_edges = 0;
    stop = 1'b1;
    wdata = 8'ha5;
    strobe(2);
    cyc(100);
    check(sck_edges[7:0], 8'h00);
    check({o_txe, o_en}, 8'h01);
    stop = 1'b0;
    wait_rx();
    cyc(20);
    check(far.rx_byte, 8'ha5);
    check(o_rx_data, 8'h9a);
    check(sck_edges[7:0], 8'h08);
    strobe(0);
    strobe(1);
    en(1'b0);
  endtask : t_stop

  task automatic t_slave_rx();
    mst = 1'b0;
    rx_en = 1'b1;
    en(1'b1);
    far.select(1'b1);
    cyc(10);
    check(o_miso_oe, 1'b1);
    far.select(1'b0);
    cyc(10);
    check(o_miso_oe, 1'b0);
    far.send_byte(8'h69, 1'b0);
    cyc(50);
    check(o_rxf, 1'b0);
    far.send_byte(8'h96, 1'b1);
    wait_rx();
    check(o_rx_data, 8'h96);
    check({rx_irq, rx_dma}, 8'h02);
    en(1'b0);
    check({o_rxf, rx_irq, o_txe, o_miso_oe}, 8'h0e);
    strobe(1);
    check(o_rxf, 1'b1);
    strobe(0);
    strobe(1);
    check({o_rxf, rx_irq}, 8'h00);
  endtask : t_slave_rx

  task automatic t_dma_rx();
    // other phase and polarity, same sampling edge as the far end's frames
    clock_phase = 1'b0;
    cpol = 1'b1;
    dma = 1'b1;
    en(1'b1);
    far.send_byte(8'ha7, 1'b1);
    wait_rx();
    check({rx_irq, rx_dma}, 8'h01);
    check(o_rx_data, 8'ha7);
    strobe(1);
    check({o_rxf, rx_dma}, 8'h00);
    dma = 1'b0;
    clock_phase = 1'b1;
    cpol = 1'b0;
  endtask : t_dma_rx

  task automatic t_break();
    far.send_byte(8'h5a, 1'b1);
    wait_rx();
    strobe(0);
    brk = 1'b1;
    strobe(1);
    check(o_rxf, 1'b1);
    brk = 1'b0;
    strobe(1);
    check(o_rxf, 1'b0);
    far.send_byte(8'h3f, 1'b1);
    wait_rx();
    brk = 1'b1;
    bce = 1'b1;
    strobe(0);
    strobe(1);
    check(o_rxf, 1'b0);
    brk = 1'b0;
    bce = 1'b0;
    cyc(5);
    check(o_rxf, 1'b0);
    en(1'b0);
  endtask : t_break

  task automatic t_fault();
    mst = 1'b1;
    err_en = 1'b1;
    en(1'b1);
    far.select(1'b1);
    cyc(20);
    check({o_sf, o_en, err_irq}, 8'h02);
    far.select(1'b0);
    cyc(5);
    sf_en = 1'b1;
    cyc(5);
    check(o_sf, 1'b0);
    far.select(1'b1);
    cyc(20);
    check({o_sf, err_irq, o_en, o_txe}, 8'h0d);
    far.select(1'b0);
    sf_en = 1'b0;
    strobe(3);
    check(o_sf, 1'b1);
    strobe(0);
    strobe(3);
    check({o_sf, err_irq}, 8'h00);
  endtask : t_fault

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial begin
    {unit_wr, unit_val, dma, tx_en, rx_en, err_en, sf_en} = 7'h00;
    {brk, bce, st_rd, d_rd, d_wr, c_wr} = 6'h00;
    {clock_phase, cpol, stop} = 3'h4;
    mst = 1'b1;
    wdata = 8'h00;
    error_cnt = 0;
    n_compared = 0;
    sck_edges = 0;
    i_rst_n = 1'b0;
    cyc(4);
    i_rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_tx_req();
    t_master_xfer();
    t_stop();
    t_slave_rx();
    t_dma_rx();
    t_break();
    t_fault();
    give_verdict();
  end
endmodule : spi_request_reset_pin_control_test
